/* shared/mca_pkg.sv */
package mca_pkg;
   // ---------------------------------------------------------------
   // Program memory and fixed fetch locations
   // ---------------------------------------------------------------
   localparam int PM_DEPTH = 1024;
   localparam int PM_AW = 10;
   localparam int PAGE_BITS = 8;
   localparam logic [9:0] PC_RST = 10'h000;
   localparam logic [9:0] VEC_IBF = 10'h003;
   localparam logic [9:0] VEC_TMR = 10'h007;
   localparam logic [9:0] PC_STEP = 10'h001;
   localparam int RF_DEPTH = 8;

   // ---------------------------------------------------------------
   // Register map, byte offsets on the APB
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_ACC = 8'h08;
   localparam logic [7:0] OFF_PADDR = 8'h0c;
   localparam logic [7:0] OFF_PDATA = 8'h10;
   localparam logic [7:0] OFF_PORT = 8'h14;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_IBF_EN = 1;
   localparam int CTRL_TMR_EN = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam int STS_CY = 16;
   localparam int STS_AC = 17;
   localparam int STS_INSERV = 18;
   localparam int STS_TPEND = 19;
   localparam int PSW_CY = 7;
   localparam int PSW_AC = 6;
   localparam logic [7:0] PSW_RST = 8'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // ---------------------------------------------------------------
   // Opcode classes, upper nibble of the opcode
   // ---------------------------------------------------------------
   localparam logic [3:0] OPC_ALU_MAX = 4'h5;
   localparam logic [3:0] OPC_MOV_R = 4'h6;
   localparam logic [3:0] OPC_ACC = 4'h7;
   localparam logic [3:0] OPC_INC_R = 4'h8;
   localparam logic [3:0] OPC_DEC_R = 4'h9;
   localparam logic [3:0] OPC_IN = 4'ha;
   localparam logic [3:0] OPC_OUT = 4'hb;
   localparam logic [3:0] OPC_JMP = 4'hc;
   localparam logic [3:0] OPC_JC = 4'hd;
   localparam logic [3:0] OPC_RETR = 4'he;
   localparam int IMM_BIT = 3;

   typedef enum logic [3:0] {
      ALU_ADD = 4'h0, ALU_ADDC = 4'h1, ALU_AND = 4'h2, ALU_OR = 4'h3,
      ALU_XOR = 4'h4, ALU_PASS = 4'h5, ALU_INC = 4'h6, ALU_DEC = 4'h7,
      ALU_CPL = 4'h8, ALU_RL = 4'h9, ALU_RR = 4'ha, ALU_RLC = 4'hb,
      ALU_RRC = 4'hc, ALU_SWAP = 4'hd, ALU_DA = 4'he, ALU_CLR = 4'hf
   } mca_alu_e;

   typedef enum logic [2:0] {
      ST_FETCH = 3'b001,
      ST_OPND = 3'b010,
      ST_EXEC = 3'b100
   } mca_state_e;
endpackage

/* verilog/mca_alu.sv */
`timescale 1ns/1ps
module mca_alu
   import mca_pkg::*;
(
   input wire logic [7:0] a_in,
   input wire logic [7:0] b_in,
   input wire logic cy_in,
   input wire logic ac_in,
   input wire mca_alu_e func_in,
   output logic [7:0] res_out,
   output logic cy_out,
   output logic ac_out,
   output logic cy_wr_out,
   output logic ac_wr_out
);
   // ---------------------------------------------------------------
   // Adder and decimal adjust paths
   // ---------------------------------------------------------------
   wire logic cin = (func_in == ALU_ADDC) & cy_in;
   wire logic [8:0] sum = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin};
   wire logic [4:0] low_sum = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin};
   wire logic lo_adj = (a_in[3:0] > 4'h9) | ac_in;
   wire logic [8:0] da1 = {1'b0, a_in} + (lo_adj ? 9'h006 : 9'h000);
   wire logic hi_adj = (da1[7:4] > 4'h9) | cy_in | da1[8];
   wire logic [8:0] da2 = da1 + (hi_adj ? 9'h060 : 9'h000);

   always_comb begin
      res_out = a_in;
      cy_out = cy_in;
      ac_out = ac_in;
      cy_wr_out = 1'b0;
      ac_wr_out = 1'b0;
      unique case (func_in)
         ALU_ADD, ALU_ADDC: begin
            res_out = sum[7:0];
            cy_out = sum[8];
            ac_out = low_sum[4];
            cy_wr_out = 1'b1;
            ac_wr_out = 1'b1;
         end
         ALU_AND: res_out = a_in & b_in;
         ALU_OR: res_out = a_in | b_in;
         ALU_XOR: res_out = a_in ^ b_in;
         ALU_PASS: res_out = b_in;
         ALU_INC: res_out = a_in + 8'h01;
         ALU_DEC: res_out = a_in - 8'h01;
         ALU_CPL: res_out = ~a_in;
         ALU_RL: res_out = {a_in[6:0], a_in[7]};
         ALU_RR: res_out = {a_in[0], a_in[7:1]};
         ALU_RLC: begin
            res_out = {a_in[6:0], cy_in};
            cy_out = a_in[7];
            cy_wr_out = 1'b1;
         end
         ALU_RRC: begin
            res_out = {cy_in, a_in[7:1]};
            cy_out = a_in[0];
            cy_wr_out = 1'b1;
         end
         ALU_SWAP: res_out = {a_in[3:0], a_in[7:4]};
         ALU_DA: begin
            // The half carry steers the low-nibble correction.
            res_out = da2[7:0];
            cy_out = hi_adj;
            cy_wr_out = 1'b1;
         end
         ALU_CLR: res_out = 8'h00;
      endcase
   end
endmodule

/* verilog/mca_core.sv */
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module mca_core
   import mca_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [7:0] port_in,
   input wire logic input_buffer_full_in,
   input wire logic timer_overflow_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic [7:0] port_out
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [2:0] ctrl_ff;
   logic [7:0] pm_ff [PM_DEPTH];
   logic [PM_AW-1:0] paddr_ff;
   logic [PM_AW-1:0] pc_ff;
   logic [PM_AW-1:0] ret_ff;
   logic [7:0] ir_ff;
   logic [7:0] opnd_ff;
   logic [7:0] acc_ff;
   logic [7:0] processor_status_word_ff;
   logic [7:0] rf_ff [RF_DEPTH];
   logic [7:0] port_ff;
   logic inserv_ff;
   logic tpend_ff;
   logic rd_done_ff;
   logic [31:0] prdata_ff;
   mca_state_e state_ff;

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   // Reads take one wait state so that read data leaves a flip-flop.
   wire logic apb_acc = psel_in & penable_in & ce_in;
   wire logic wr_en = apb_acc & pwrite_in;
   wire logic rd_cap = apb_acc & ~pwrite_in & ~rd_done_ff;
   wire logic sel_ctrl = (paddr_in == OFF_CTRL);
   wire logic sel_sts = (paddr_in == OFF_STATUS);
   wire logic sel_acc = (paddr_in == OFF_ACC);
   wire logic sel_padr = (paddr_in == OFF_PADDR);
   wire logic sel_pdat = (paddr_in == OFF_PDATA);
   wire logic sel_port = (paddr_in == OFF_PORT);
   wire logic addr_hit = sel_ctrl | sel_sts | sel_acc | sel_padr | sel_pdat | sel_port;
   wire logic [31:0] sts_word = {12'h000, tpend_ff, inserv_ff,
      processor_status_word_ff[PSW_AC], processor_status_word_ff[PSW_CY],
      6'h00, pc_ff};
   wire logic [31:0] rd_mux =
      sel_ctrl ? {29'h0, ctrl_ff} :
      sel_sts ? sts_word :
      sel_acc ? {24'h0, acc_ff} :
      sel_padr ? {22'h0, paddr_ff} :
      sel_pdat ? {24'h0, pm_ff[paddr_ff]} :
      sel_port ? {24'h0, port_ff} : 32'h0;
   wire logic pm_wr = wr_en & sel_pdat;

   assign pready_out = apb_acc & (pwrite_in | rd_done_ff);
   assign pslverr_out = pready_out & ~addr_hit;
   assign prdata_out = prdata_ff;
   assign port_out = port_ff;

   // ---------------------------------------------------------------
   // Decode of the held instruction
   // ---------------------------------------------------------------
   wire logic go = ce_in & ctrl_ff[CTRL_RUN];
   wire logic [3:0] opc = ir_ff[7:4];
   wire logic [2:0] rsel = ir_ff[2:0];
   wire logic alu_cls = (opc <= OPC_ALU_MAX);
   wire logic two_byte = (alu_cls & ir_ff[IMM_BIT]) | (opc == OPC_JMP) | (opc == OPC_JC);
   wire logic reg_op = (opc == OPC_INC_R) | (opc == OPC_DEC_R);
   wire logic acc_op = alu_cls | (opc == OPC_ACC);
   wire logic [7:0] bus_b = ir_ff[IMM_BIT] ? opnd_ff : rf_ff[rsel];
   wire mca_alu_e func =
      alu_cls ? mca_alu_e'(opc) :
      (opc == OPC_ACC) ? mca_alu_e'(ir_ff[3:0]) :
      (opc == OPC_INC_R) ? ALU_INC :
      (opc == OPC_DEC_R) ? ALU_DEC : ALU_PASS;
   wire logic [7:0] alu_a = reg_op ? rf_ff[rsel] : acc_ff;
   wire logic [7:0] alu_res;
   wire logic alu_cy;
   wire logic alu_ac;
   wire logic cy_wr;
   wire logic ac_wr;
   wire logic cy_flag = processor_status_word_ff[PSW_CY];

   mca_alu u_alu (
      .a_in(alu_a),
      .b_in(bus_b),
      .cy_in(cy_flag),
      .ac_in(processor_status_word_ff[PSW_AC]),
      .func_in(func),
      .res_out(alu_res),
      .cy_out(alu_cy),
      .ac_out(alu_ac),
      .cy_wr_out(cy_wr),
      .ac_wr_out(ac_wr)
   );

   // ---------------------------------------------------------------
   // Sequencing and interrupts
   // ---------------------------------------------------------------
   // Buffer full is a level, so it is taken again after return while it stays set.
   wire logic in_fetch = (state_ff == ST_FETCH);
   wire logic in_opnd = (state_ff == ST_OPND);
   wire logic exec_go = go & (state_ff == ST_EXEC);
   wire logic ibf_req = ctrl_ff[CTRL_IBF_EN] & input_buffer_full_in & ~inserv_ff;
   wire logic tmr_req = ctrl_ff[CTRL_TMR_EN] & tpend_ff & ~inserv_ff;
   wire logic take_ibf = go & in_fetch & ibf_req;
   wire logic take_tmr = go & in_fetch & tmr_req & ~ibf_req;
   wire logic take_any = take_ibf | take_tmr;
   wire logic fetch_go = go & in_fetch & ~take_any;
   wire logic opnd_go = go & in_opnd & two_byte;
   wire logic [7:0] fetch_byte = pm_ff[pc_ff];
   wire logic [PM_AW-1:0] pc_inc = pc_ff + PC_STEP;
   wire logic jc_take = exec_go & (opc == OPC_JC) & cy_flag;
   wire logic [PM_AW-1:0] nxt_pc =
      take_ibf ? VEC_IBF :
      take_tmr ? VEC_TMR :
      (fetch_go | opnd_go) ? pc_inc :
      (exec_go & (opc == OPC_JMP)) ? {ir_ff[1:0], opnd_ff} :
      jc_take ? {pc_ff[PM_AW-1:PAGE_BITS], opnd_ff} :
      (exec_go & (opc == OPC_RETR)) ? ret_ff : pc_ff;
   wire mca_state_e nxt_state =
      ~go ? state_ff :
      in_fetch ? (take_any ? ST_FETCH : ST_OPND) :
      in_opnd ? ST_EXEC : ST_FETCH;
   // The timer event is sticky; a new overflow in the taking cycle survives.
   wire logic nxt_tpend = timer_overflow_in | (tpend_ff & ~take_tmr);
   wire logic nxt_inserv = take_any | (inserv_ff & ~(exec_go & (opc == OPC_RETR)));
   wire logic acc_wr = exec_go & (acc_op | (opc == OPC_IN));
   wire logic [7:0] nxt_acc = (opc == OPC_IN) ? port_in : alu_res;
   wire logic [7:0] nxt_psw = {
      (exec_go & acc_op & cy_wr) ? alu_cy : processor_status_word_ff[PSW_CY],
      (exec_go & acc_op & ac_wr) ? alu_ac : processor_status_word_ff[PSW_AC],
      6'h00};
   wire logic [7:0] rf_res = reg_op ? alu_res : acc_ff;
   wire logic rf_wr = exec_go & (reg_op | (opc == OPC_MOV_R));

   // ---------------------------------------------------------------
   // Core registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         state_ff <= ST_FETCH;
         pc_ff <= PC_RST;
         ret_ff <= PC_RST;
         ir_ff <= BYTE_RST;
         opnd_ff <= BYTE_RST;
         acc_ff <= BYTE_RST;
         processor_status_word_ff <= PSW_RST;
         port_ff <= BYTE_RST;
         inserv_ff <= 1'b0;
         tpend_ff <= 1'b0;
      end else if (ce_in) begin
         state_ff <= nxt_state;
         pc_ff <= nxt_pc;
         tpend_ff <= nxt_tpend;
         inserv_ff <= nxt_inserv;
         processor_status_word_ff <= nxt_psw;
         if (take_any) begin
            ret_ff <= pc_ff;
         end
         if (fetch_go) begin
            ir_ff <= fetch_byte;
         end
         if (opnd_go) begin
            opnd_ff <= fetch_byte;
         end
         if (acc_wr) begin
            acc_ff <= nxt_acc;
         end
         if (exec_go & (opc == OPC_OUT)) begin
            port_ff <= acc_ff;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < RF_DEPTH; gi++) begin : g_rf
         always_ff @(posedge ref_clk_in) begin
            if (reset_in) begin
               rf_ff[gi] <= BYTE_RST;
            end else if (ce_in & rf_wr & (rsel == 3'(gi))) begin
               rf_ff[gi] <= rf_res;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Bus registers and program loader
   // ---------------------------------------------------------------
   // The program array has no reset to keep it cheap; load it before run.
   always_ff @(posedge ref_clk_in) begin
      if (ce_in & pm_wr) begin
         pm_ff[paddr_ff] <= pwdata_in[7:0];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         ctrl_ff <= CTRL_RST;
         paddr_ff <= PC_RST;
         rd_done_ff <= 1'b0;
         prdata_ff <= 32'h0;
      end else if (ce_in) begin
         rd_done_ff <= rd_cap;
         if (rd_cap) begin
            prdata_ff <= rd_mux;
         end
         if (wr_en & sel_ctrl) begin
            ctrl_ff <= pwdata_in[2:0];
         end
         if (wr_en & sel_padr) begin
            paddr_ff <= pwdata_in[PM_AW-1:0];
         end else if (pm_wr) begin
            paddr_ff <= paddr_ff + PC_STEP;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (reset_in);

   reset_fetch_a: assert property ($fell(reset_in) |-> pc_ff == PC_RST && in_fetch)
      else $error("first fetch after reset is not at address zero");
   ibf_vector_a: assert property (take_ibf |=> pc_ff == VEC_IBF && inserv_ff)
      else $error("buffer full interrupt did not vector to three");
   tmr_vector_a: assert property (take_tmr |=> pc_ff == VEC_TMR && inserv_ff)
      else $error("timer interrupt did not vector to seven");
   irq_prio_a: assert property (take_tmr |-> !ibf_req && state_ff == ST_FETCH)
      else $error("timer taken over buffer full or mid instruction");
   pc_step_a: assert property (fetch_go |=> pc_ff == $past(pc_inc) && in_opnd)
      else $error("program counter did not step by one");
   op_capture_a: assert property (fetch_go |=> ir_ff == $past(fetch_byte))
      else $error("opcode not captured on fetch");
   carry_add_a: assert property (exec_go && acc_op && cy_wr |=> cy_flag == $past(alu_cy))
      else $error("carry flag missed the overflow bit");
   acc_dest_a: assert property (exec_go && acc_op |=> acc_ff == $past(alu_res))
      else $error("accumulator did not take the result");
   page_jump_a: assert property (jc_take |=> pc_ff[9:8] == $past(pc_ff[9:8]))
      else $error("conditional jump left its page");
   // A new overflow arriving while the old one is taken must not be lost.
   tpend_set_a: assert property (timer_overflow_in && ce_in |=> tpend_ff)
      else $error("timer overflow was not latched as pending");
   nest_block_a: assert property (inserv_ff |-> !take_any)
      else $error("interrupt taken while another is in service");
   ibf_take_a: assert property (go && in_fetch && ibf_req |-> take_ibf)
      else $error("enabled buffer full was not taken at a boundary");
   half_carry_a: assert property (exec_go && acc_op && ac_wr
      |=> processor_status_word_ff[PSW_AC] == $past(alu_ac))
      else $error("half carry flag missed the low nibble carry");
   in_port_a: assert property (exec_go && opc == OPC_IN |=> acc_ff == $past(port_in))
      else $error("input port byte did not reach the accumulator");
   rf_dest_a: assert property (exec_go && reg_op
      |=> rf_ff[$past(rsel)] == $past(alu_res))
      else $error("register operation result was not written back");
   one_byte_a: assert property (go && in_opnd && !two_byte |=> pc_ff == $past(pc_ff))
      else $error("counter stepped without a program byte");
   pm_wrap_a: assert property (fetch_go && pc_ff == 10'h3ff |=> pc_ff == 10'h000)
      else $error("counter did not wrap at the end of program memory");
   jmp_target_a: assert property (exec_go && opc == OPC_JMP
      |=> pc_ff[PAGE_BITS-1:0] == $past(opnd_ff))
      else $error("jump did not load the low counter byte");
endmodule

/* sim/mca_far_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Far side: port source and interrupt causes
// ---------------------------------------------------------------
module mca_far_model #(
   parameter logic [7:0] PORT_VAL = 8'h6d
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic [7:0] port_out_in,
   input wire logic raise_ibf_in,
   input wire logic tmr_req_in,
   output logic [7:0] port_in_out,
   output logic ibf_out,
   output logic tmr_out
);
   logic [7:0] seen_ff;
   // The buffer stays full until the core writes a new port byte, so a handler
   // that forgets to answer is taken again and again.
   always_ff @(posedge ref_clk_in) begin
      seen_ff <= port_out_in;
      tmr_out <= tmr_req_in & ~reset_in;
      if (reset_in) begin
         ibf_out <= 1'b0;
      end else if (raise_ibf_in) begin
         ibf_out <= 1'b1;
      end else if (port_out_in !== seen_ff) begin
         ibf_out <= 1'b0;
      end
   end
   assign port_in_out = PORT_VAL;
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import mca_pkg::*;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic ref_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic raise_ibf = 1'b0;
   logic tmr_req = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] port_rd;
   logic [7:0] port_wr;
   logic input_buffer_full;
   logic tmr;
   logic [31:0] rd_q;
   logic err_q;
   int n_errors = 0;
   int n_compared = 0;
   mca_core dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .ce_in(ce),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .port_in(port_rd), .input_buffer_full_in(input_buffer_full),
      .timer_overflow_in(tmr), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .port_out(port_wr));
   mca_far_model far_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .port_out_in(port_wr),
      .raise_ibf_in(raise_ibf), .tmr_req_in(tmr_req), .port_in_out(port_rd),
      .ibf_out(input_buffer_full), .tmr_out(tmr));
   initial begin
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end
   // ---------------------------------------------------------------
   // Bus and check tasks
   // ---------------------------------------------------------------
   task automatic print_verdict();
      if (n_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_in);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         print_verdict();
      end
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic do_reset();
      reset_in <= 1'b1;
      repeat (10) @(posedge ref_clk_in);
      reset_in <= 1'b0;
   endtask
   task automatic load(input logic [9:0] at, input logic [7:0] b[$]);
      apb(1'b1, OFF_PADDR, {22'h0, at});
      foreach (b[i]) apb(1'b1, OFF_PDATA, {24'h0, b[i]});
   endtask
   // Polling the counter rather than waiting a fixed time keeps the bench
   // independent of how many cycles each instruction takes.
   task automatic wait_pc(input logic [9:0] lo);
      int n;
      for (n = 0; n < 40; n++) begin
         apb(1'b0, OFF_STATUS, 32'h0);
         if (rd_q[9:0] === lo || rd_q[9:0] === lo + 10'h001) break;
      end
      if (n == 40) begin
         n_errors++;
         print_verdict();
      end
   endtask
   task automatic wait_port(input logic [7:0] v);
      int n;
      for (n = 0; n < 300 && port_wr !== v; n++) @(posedge ref_clk_in);
      if (port_wr !== v) begin
         n_errors++;
         print_verdict();
      end
   endtask
   // ---------------------------------------------------------------
   // Program table: start A, four program bytes, result, flags, flag mask
   // ---------------------------------------------------------------
   logic [63:0] alu_tab [19] = '{
      64'hff_08_01_d0_05_00_00_01,
      64'h9c_08_7a_f0_f0_16_03_03, 64'hff_08_01_18_10_11_00_03, 64'hf0_28_3c_f0_f0_30_00_00,
      64'h30_38_0c_f0_f0_3c_00_00, 64'h5a_48_ff_f0_f0_a5_00_00, 64'hff_76_f0_f0_f0_00_00_00,
      64'h00_77_f0_f0_f0_ff_00_00, 64'h5a_78_f0_f0_f0_a5_00_00, 64'h81_79_f0_f0_f0_03_00_01,
      64'h81_7a_f0_f0_f0_c0_00_01, 64'h81_7b_f0_f0_f0_02_01_01, 64'h81_7c_f0_f0_f0_40_01_01,
      64'h3c_7d_f0_f0_f0_c3_00_00, 64'h19_08_28_7e_f0_47_00_01, 64'h99_08_01_7e_f0_00_01_01,
      64'h77_7f_f0_f0_f0_00_00_00, 64'h41_60_80_50_f0_42_00_00, 64'h00_a0_b0_f0_f0_6d_00_00};
   initial begin
      repeat (90000) @(posedge ref_clk_in);
      n_errors++;
      print_verdict();
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [63:0] e;
      logic [7:0] q[$];
      do_reset();
      apb(1'b0, OFF_STATUS, 32'h0);
      check(rd_q, {22'h0, PC_RST});
      apb(1'b0, OFF_CTRL, 32'h0);
      check(rd_q, {29'h0, CTRL_RST});
      apb(1'b1, OFF_ACC, 32'hff);
      apb(1'b0, OFF_ACC, 32'h0);
      check(rd_q, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      check({31'h0, err_q}, 32'h1);
      check(rd_q, 32'h0);
      for (int i = 0; i < 19; i++) begin
         e = alu_tab[i];
         do_reset();
         q = {8'h58, e[63:56], e[55:48], e[47:40], e[39:32], e[31:24], 8'hc0, 8'h06};
         load(10'h000, q);
         apb(1'b1, OFF_CTRL, 32'h1 << CTRL_RUN);
         wait_pc(10'h006);
         apb(1'b0, OFF_ACC, 32'h0);
         check(rd_q, {24'h0, e[23:16]});
         apb(1'b0, OFF_STATUS, 32'h0);
         check({30'h0, rd_q[STS_AC], rd_q[STS_CY]} & e[7:0], e[15:8] & e[7:0]);
         check({24'h0, port_wr}, (e[55:48] == 8'ha0) ? 32'h6d : 32'h0);
      end
      // Jump into the top page, then run off its end back into page zero.
      do_reset();
      q = {8'hc3, 8'hff, 8'hc0, 8'h02};
      load(10'h000, q);
      q = {8'h58};
      load(10'h3ff, q);
      apb(1'b1, OFF_CTRL, 32'h1 << CTRL_RUN);
      wait_pc(10'h002);
      apb(1'b0, OFF_ACC, 32'h0);
      check(rd_q, 32'hc3);
      // Both causes raised while masked, then unmasked together.
      do_reset();
      q = {8'hc0, 8'h10, 8'hf0, 8'h58, 8'h33, 8'hb0, 8'he0, 8'h58, 8'h77, 8'hb0, 8'he0};
      load(10'h000, q);
      q = {8'hc0, 8'h10};
      load(10'h010, q);
      apb(1'b1, OFF_CTRL, 32'h1 << CTRL_RUN);
      wait_pc(10'h010);
      raise_ibf <= 1'b1;
      tmr_req <= 1'b1;
      @(posedge ref_clk_in);
      raise_ibf <= 1'b0;
      tmr_req <= 1'b0;
      repeat (10) @(posedge ref_clk_in);
      apb(1'b0, OFF_STATUS, 32'h0);
      check({30'h0, rd_q[STS_TPEND], rd_q[STS_INSERV]}, 32'h2);
      apb(1'b0, OFF_ACC, 32'h0);
      check(rd_q, 32'h0);
      apb(1'b1, OFF_CTRL, 32'h7);
      wait_port(8'h33);
      wait_port(8'h77);
      wait_pc(10'h010);
      apb(1'b0, OFF_STATUS, 32'h0);
      check({30'h0, rd_q[STS_TPEND], rd_q[STS_INSERV]}, 32'h0);
      apb(1'b0, OFF_ACC, 32'h0);
      check(rd_q, 32'h77);
      print_verdict();
   end
endmodule
